// ### rtl/dcbs_config_sequencer.sv
// Configuration word of the self-refresh DRAM and the burst address sequencer it steers.
// Assumes the command decoder hands over a register write, a transaction start with the
// command-address linear bit, and one step pulse per transferred 16-bit word.
// Notes on behaviour
// - Single die: bit 15 resets to 1; writing 0 enters deep power down.
// - Stacked part: bit 15 reserved, no deep power down effect.
// - Bits 14-12 select output impedance, eight codes, 000 default 34 ohms.
// - Bits 7-4 select latency 5,6,3,4 clocks; other codes reserved, default 6.
// - Single die bit 3: 0 variable latency, 1 fixed double latency (default).
// - Stacked part: bit 3 reserved and fixed at 1.
// - Fixed latency always signals refresh latency and doubles initial latency.
// - Variable latency adds second period only when refresh needed at start.
// - Bit 2: 0 hybrid wrapped bursts, 1 legacy wrap (default).
// - Bits 1-0 wrap length: 128, 64, 16, 32 bytes; default 32.
// - Legacy wrap steps up to group end, wraps to group start.
// - Hybrid wraps once, then linear from next group until chip select high.
// - Linear command bit set forces linear burst regardless of wrap settings.
// - Strobe driven high in command cycles when extra latency is inserted.
// - Reset loads the default configuration word.
`timescale 1ns/1ps
module dcbs_config_sequencer #(
  parameter bit                        STACKED = 1'b0
) (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    cfg_wr,
  input  wire logic [dcbs_pkg::CFG_W-1:0]  cfg_wdata,
  input  wire logic                    xfer_start,
  input  wire logic                    xfer_linear,
  input  wire logic                    xfer_register,
  input  wire logic [dcbs_pkg::ADDR_W-1:0] xfer_addr,
  input  wire logic                    refresh_needed,
  input  wire logic                    word_step,
  input  wire logic                    cs_n,
  output logic [dcbs_pkg::CFG_W-1:0]   protocol_config_word,
  output logic                         deep_power_down,
  output logic [6:0]                   drive_ohms,
  output logic [3:0]                   latency_clks,
  output logic                         read_write_strobe_mask,
  output logic                         double_latency,
  output logic [dcbs_pkg::ADDR_W-1:0]  burst_addr,
  output logic                         burst_active
);
  import dcbs_pkg::*;

  // ==========================================================================
  // State
  typedef struct packed {
    logic [CFG_W-1:0]  cfg;
    logic              dpd;
    logic [6:0]        ohms;
    logic [3:0]        lat;
    logic              strobe;
    logic              dbl;
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] start;
    logic              wrapping;
    logic              hybrid;
    logic              linear;
    logic              active;
  } dcbs_state_t;

  dcbs_state_t st_r;
  dcbs_state_t st_nxt;

  // Group mask in words for a wrap code; used for stepping and for the end test
  function automatic logic [ADDR_W-1:0] dcbs_mask(input logic [1:0] code);
    unique case (code)
      WRAP_128B: dcbs_mask = MASK_128B;
      WRAP_64B:  dcbs_mask = MASK_64B;
      WRAP_16B:  dcbs_mask = MASK_16B;
      default:   dcbs_mask = MASK_32B;
    endcase
  endfunction

  // Latency clocks for a code; reserved codes keep six as a safe worst case
  function automatic logic [3:0] dcbs_lat(input logic [3:0] code);
    unique case (code)
      LAT_CODE_5: dcbs_lat = LAT_CLKS_5;
      LAT_CODE_3: dcbs_lat = LAT_CLKS_3;
      LAT_CODE_4: dcbs_lat = LAT_CLKS_4;
      default:    dcbs_lat = LAT_CLKS_6;
    endcase
  endfunction

  function automatic logic [6:0] dcbs_ohms(input logic [2:0] code);
    unique case (code)
      3'h1:    dcbs_ohms = OHM_115;
      3'h2:    dcbs_ohms = OHM_67;
      3'h3:    dcbs_ohms = OHM_46;
      3'h5:    dcbs_ohms = OHM_27;
      3'h6:    dcbs_ohms = OHM_22;
      3'h7:    dcbs_ohms = OHM_19;
      default: dcbs_ohms = OHM_34;
    endcase
  endfunction

  logic [ADDR_W-1:0] mask;
  logic [ADDR_W-1:0] inc;
  logic [ADDR_W-1:0] wrapped;
  logic [CFG_W-1:0]  wdata;
  logic              fixed_lat;

  // ==========================================================================
  // Next-state logic
  always_comb begin
    st_nxt    = st_r;
    mask      = dcbs_mask(st_r.cfg[WRAP_HI:WRAP_LO]);
    inc       = st_r.addr + 32'h00000001;
    wrapped   = (st_r.addr & ~mask) | (inc & mask);
    wdata     = cfg_wdata;
    if (STACKED) begin
      wdata[DPD_BIT] = 1'b1;
      wdata[FIX_BIT] = 1'b1;
    end
    if (cfg_wr) begin
      st_nxt.cfg = wdata;
    end
    st_nxt.dpd  = ~STACKED & ~st_nxt.cfg[DPD_BIT];
    st_nxt.ohms = dcbs_ohms(st_nxt.cfg[DRV_HI:DRV_LO]);
    st_nxt.lat  = dcbs_lat(st_nxt.cfg[LAT_HI:LAT_LO]);
    fixed_lat   = st_r.cfg[FIX_BIT];
    st_nxt.strobe = 1'b0;
    if (xfer_start) begin
      st_nxt.strobe   = ~xfer_register | fixed_lat ? (fixed_lat | refresh_needed) : 1'b0;
      st_nxt.strobe   = fixed_lat | refresh_needed;
      st_nxt.dbl      = fixed_lat | refresh_needed;
      st_nxt.addr     = xfer_addr;
      st_nxt.start    = xfer_addr;
      st_nxt.linear   = xfer_linear;
      st_nxt.hybrid   = ~st_r.cfg[LEGACY_BIT];
      st_nxt.wrapping = ~xfer_linear;
      st_nxt.active   = 1'b1;
    end else if (cs_n) begin
      st_nxt.active = 1'b0;
    end else if (word_step && st_r.active) begin
      if (st_r.linear || !st_r.wrapping) begin
        st_nxt.addr = inc;
      end else if (wrapped == st_r.start && st_r.hybrid) begin
        st_nxt.addr     = (st_r.start & ~mask) + mask + 32'h00000001;
        st_nxt.wrapping = 1'b0;
      end else begin
        st_nxt.addr = wrapped;
      end
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r          <= '0;
      st_r.cfg      <= CFG_RESET;
      st_r.ohms     <= OHM_34;
      st_r.lat      <= LAT_CLKS_6;
      st_r.dbl      <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign protocol_config_word   = st_r.cfg;
  assign deep_power_down        = st_r.dpd;
  assign drive_ohms             = st_r.ohms;
  assign latency_clks           = st_r.lat;
  assign read_write_strobe_mask = st_r.strobe;
  assign double_latency         = st_r.dbl;
  assign burst_addr             = st_r.addr;
  assign burst_active           = st_r.active;

  // ==========================================================================
  // Assertions
  a_fixed_strobe_high: assert property (@(posedge clk) disable iff (rst)
    xfer_start && st_r.cfg[FIX_BIT] |=> read_write_strobe_mask && double_latency)
    else $error("fixed latency did not raise strobe");
  a_variable_strobe: assert property (@(posedge clk) disable iff (rst)
    xfer_start && !st_r.cfg[FIX_BIT] |=> read_write_strobe_mask == $past(refresh_needed))
    else $error("variable latency strobe wrong");
  a_cfg_write_taken: assert property (@(posedge clk) disable iff (rst)
    cfg_wr && !STACKED |=> protocol_config_word == $past(cfg_wdata))
    else $error("config write not stored");
  a_stacked_fixed: assert property (@(posedge clk) disable iff (rst)
    STACKED |-> protocol_config_word[FIX_BIT] && !deep_power_down)
    else $error("stacked part reserved bits changed");
  a_dpd_follows: assert property (@(posedge clk) disable iff (rst)
    cfg_wr && !STACKED && !cfg_wdata[DPD_BIT] |=> deep_power_down)
    else $error("deep power down not entered");
  a_linear_step: assert property (@(posedge clk) disable iff (rst)
    st_r.linear && st_r.active && word_step && !cs_n && !xfer_start
      |=> burst_addr == $past(burst_addr) + 32'h00000001)
    else $error("linear burst did not step");
  a_legacy_in_group: assert property (@(posedge clk) disable iff (rst)
    st_r.active && !st_r.linear && !st_r.hybrid && word_step && !cs_n && !xfer_start
      |=> (burst_addr & ~mask) == ($past(burst_addr) & ~$past(mask)))
    else $error("legacy wrap left its group");
  a_latency_decode: assert property (@(posedge clk) disable iff (rst)
    protocol_config_word[LAT_HI:LAT_LO] == LAT_CODE_3 && $stable(protocol_config_word)
      |-> latency_clks == LAT_CLKS_3)
    else $error("latency decode wrong");
endmodule

// ### rtl/dcbs_pkg.sv
// Constants for the configuration word and burst sequencer.
// Assumes a single synchronous clock domain and an active-high synchronous reset.
package dcbs_pkg;
  // ==========================================================================
  // Configuration word layout
  localparam int unsigned          CFG_W          = 16;
  localparam int unsigned          DPD_BIT        = 15;
  localparam int unsigned          DRV_HI         = 14;
  localparam int unsigned          DRV_LO         = 12;
  localparam int unsigned          RSV_HI         = 11;
  localparam int unsigned          RSV_LO         = 8;
  localparam int unsigned          LAT_HI         = 7;
  localparam int unsigned          LAT_LO         = 4;
  localparam int unsigned          FIX_BIT        = 3;
  localparam int unsigned          LEGACY_BIT     = 2;
  localparam int unsigned          WRAP_HI        = 1;
  localparam int unsigned          WRAP_LO        = 0;
  localparam logic [CFG_W-1:0]     CFG_RESET      = 16'h8f1f;
  localparam logic [CFG_W-1:0]     CFG_RSV_ONES   = 16'h0f00;
  // ==========================================================================
  // Latency codes and clock counts
  localparam logic [3:0]           LAT_CODE_5     = 4'h0;
  localparam logic [3:0]           LAT_CODE_6     = 4'h1;
  localparam logic [3:0]           LAT_CODE_3     = 4'he;
  localparam logic [3:0]           LAT_CODE_4     = 4'hf;
  localparam logic [3:0]           LAT_CLKS_3     = 4'h3;
  localparam logic [3:0]           LAT_CLKS_4     = 4'h4;
  localparam logic [3:0]           LAT_CLKS_5     = 4'h5;
  localparam logic [3:0]           LAT_CLKS_6     = 4'h6;
  // ==========================================================================
  // Wrap length codes and group sizes in 16-bit words
  localparam logic [1:0]           WRAP_128B      = 2'h0;
  localparam logic [1:0]           WRAP_64B       = 2'h1;
  localparam logic [1:0]           WRAP_16B       = 2'h2;
  localparam logic [1:0]           WRAP_32B       = 2'h3;
  localparam int unsigned          ADDR_W         = 32;
  localparam logic [ADDR_W-1:0]    MASK_128B      = 32'h0000003f;
  localparam logic [ADDR_W-1:0]    MASK_64B       = 32'h0000001f;
  localparam logic [ADDR_W-1:0]    MASK_32B       = 32'h0000000f;
  localparam logic [ADDR_W-1:0]    MASK_16B       = 32'h00000007;
  // ==========================================================================
  // Drive impedance in ohms per code
  localparam logic [6:0]           OHM_34         = 7'h22;
  localparam logic [6:0]           OHM_115        = 7'h73;
  localparam logic [6:0]           OHM_67         = 7'h43;
  localparam logic [6:0]           OHM_46         = 7'h2e;
  localparam logic [6:0]           OHM_27         = 7'h1b;
  localparam logic [6:0]           OHM_22         = 7'h16;
  localparam logic [6:0]           OHM_19         = 7'h13;
endpackage

// ### tb/dcbs_host_model.sv
// Memory controller model that writes the configuration word and runs bursts.
// Assumes its tasks are called just after a falling edge of clk.
`timescale 1ns/1ps
module dcbs_host_model (
  input  wire logic                        clk,
  output logic                             cfg_wr,
  output logic [dcbs_pkg::CFG_W-1:0]       cfg_wdata,
  output logic                             xfer_start,
  output logic                             xfer_linear,
  output logic                             xfer_register,
  output logic [dcbs_pkg::ADDR_W-1:0]      xfer_addr,
  output logic                             refresh_needed,
  output logic                             word_step,
  output logic                             cs_n
);
  import dcbs_pkg::*;
  // Idle values; released buses show the inverse of their last value
  initial begin
    {cfg_wr, xfer_start, xfer_linear, xfer_register, refresh_needed, word_step} = 6'h00;
    cfg_wdata = 16'h0000;
    xfer_addr = 32'h00000000;
    cs_n      = 1'b1;
  end
  // one whole word, reserved bits ones
  task automatic write_cfg(input logic [CFG_W-1:0] w);
    cfg_wr    = 1'b1;
    cfg_wdata = w | CFG_RSV_ONES;
    @(negedge clk);
    cfg_wr    = 1'b0;
    cfg_wdata = ~cfg_wdata;
    // Let one edge pass idle so a following write never re-raises the strobe at once
    @(negedge clk);
  endtask
  // Command cycle of a memory read, held for one taking edge
  task automatic start(input logic [ADDR_W-1:0] a, input logic lin, input logic rf);
    {cs_n, xfer_start, xfer_linear, refresh_needed, xfer_addr} = {2'b01, lin, rf, a};
    @(negedge clk);
    xfer_start = 1'b0;
    xfer_addr  = ~a;
  endtask
  task automatic step(input logic on);
    word_step = on;
  endtask
  // Chip select high ends the burst
  task automatic stop();
    {word_step, cs_n} = 2'b01;
    refresh_needed    = ~refresh_needed;
  endtask
endmodule

// ### tb/testbench.sv
// Self-checking bench for the configuration word and burst sequencer.
// Assumes the single-die variant with a stacked copy alongside, and a host model on the command side.
`timescale 1ns/1ps
module testbench;
  import dcbs_pkg::*;
  logic clk, rst, cfg_wr, xfer_start, xfer_linear, xfer_register;
  logic refresh_needed, word_step, cs_n, dpd, strobe, dbl, active, dpd_stk;
  logic [CFG_W-1:0]  cfg_wdata, cfg_q, cfg_now, cfg_stk;
  logic [ADDR_W-1:0] xfer_addr, burst_addr;
  logic [6:0]        ohms;
  logic [3:0]        lat;
  int                n_mismatch, check_count, cycles;
  logic [6:0] ohm_t [8] = '{OHM_34, OHM_115, OHM_67, OHM_46, OHM_34, OHM_27, OHM_22, OHM_19};
  logic [3:0] lc_t  [4] = '{LAT_CODE_5, LAT_CODE_6, LAT_CODE_3, LAT_CODE_4};
  logic [3:0] lk_t  [4] = '{LAT_CLKS_5, LAT_CLKS_6, LAT_CLKS_3, LAT_CLKS_4};
  // Burst table: low nibble of the word, start, linear bit, words
  logic [3:0] bn_t [6] = '{4'ha, 4'hd, 4'h8, 4'he, 4'hb, 4'ha};
  logic [31:0] ba_t [6] = '{32'h0c, 32'h2e, 32'h03, 32'h02, 32'h1e, 32'h03};
  int         bl_t [6] = '{0, 0, 0, 0, 0, 1};
  int         bw_t [6] = '{12, 34, 70, 10, 20, 8};

  dcbs_host_model i_host (.clk(clk), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
    .xfer_start(xfer_start), .xfer_linear(xfer_linear), .xfer_register(xfer_register),
    .xfer_addr(xfer_addr), .refresh_needed(refresh_needed), .word_step(word_step),
    .cs_n(cs_n));
  dcbs_config_sequencer #(.STACKED(1'b0)) i_dut (.clk(clk), .rst(rst), .cfg_wr(cfg_wr),
    .cfg_wdata(cfg_wdata), .xfer_start(xfer_start), .xfer_linear(xfer_linear),
    .xfer_register(xfer_register), .xfer_addr(xfer_addr), .refresh_needed(refresh_needed),
    .word_step(word_step), .cs_n(cs_n), .protocol_config_word(cfg_q),
    .deep_power_down(dpd), .drive_ohms(ohms), .latency_clks(lat),
    .read_write_strobe_mask(strobe), .double_latency(dbl), .burst_addr(burst_addr),
    .burst_active(active));
  // Stacked variant on the same stimulus; only its config word and deep power down output are compared
  dcbs_config_sequencer #(.STACKED(1'b1)) i_dut_stk (.clk(clk), .rst(rst), .cfg_wr(cfg_wr),
    .cfg_wdata(cfg_wdata), .xfer_start(xfer_start), .xfer_linear(xfer_linear),
    .xfer_register(xfer_register), .xfer_addr(xfer_addr), .refresh_needed(refresh_needed),
    .word_step(word_step), .cs_n(cs_n), .protocol_config_word(cfg_stk),
    .deep_power_down(dpd_stk), .drive_ohms(), .latency_clks(),
    .read_write_strobe_mask(), .double_latency(), .burst_addr(), .burst_active());

  // ==========================================================================
  // Clock, 25 ns period, and a hang guard well past the expected run
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      results();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [CFG_W-1:0] w);
    i_host.write_cfg(w);
    cfg_now = w | CFG_RSV_ONES;
  endtask
  // Walk one burst; expected order worked out from the group size
  task automatic burst(input logic [31:0] a, input logic ln, input logic rf,
                       input logic es, input int n);
    logic [31:0] g, b, e;
    g = (cfg_now[1:0] == 2'h0) ? 64 : (cfg_now[1:0] == 2'h1) ? 32 :
        (cfg_now[1:0] == 2'h2) ? 8 : 16;
    b = a & ~(g - 1);
    i_host.start(a, ln, rf);
    chk(strobe, es);
    chk({dbl, active}, {es, 1'b1});
    for (int i = 0; i < n; i++) begin
      if (ln) e = a + i;
      else if (i < g || cfg_now[2]) e = b + ((a - b + i) % g);
      else e = b + g + (i - g);
      chk(burst_addr, e);
      i_host.step(1'b1);
      @(negedge clk);
    end
    i_host.stop();
    @(negedge clk);
    chk(active, 1'b0);
  endtask
  task automatic results();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    cfg_now = CFG_RESET;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    chk(cfg_q, CFG_RESET);
    chk({dpd, ohms, lat, dbl}, {1'b0, OHM_34, LAT_CLKS_6, 1'b1});
    // Every drive code, every legal latency code
    for (int i = 0; i < 8; i++) begin
      wr({1'b1, 3'(i), 4'hf, lc_t[i % 4], 4'hf});
      chk(cfg_q, cfg_now);
      chk({ohms, lat}, {ohm_t[i], lk_t[i % 4]});
    end
    wr(16'h0f1f);
    chk(dpd, 1'b1);
    chk({dpd_stk, cfg_stk}, {1'b0, 16'h8f1f});
    wr(16'h8f1f);
    chk(dpd, 1'b0);
    // Fixed latency, then variable without and with refresh
    burst(32'h10, 1'b1, 1'b0, 1'b1, 2);
    chk(dbl, 1'b1);
    wr(16'h8f17);
    chk(cfg_stk, 16'h8f1f);
    burst(32'h10, 1'b1, 1'b0, 1'b0, 2);
    burst(32'h10, 1'b1, 1'b1, 1'b1, 2);
    // Legacy bursts at 64 and 16 byte wrap, hybrid at 16, 128 and 32, linear at 16
    for (int k = 0; k < 6; k++) begin
      wr({8'h8f, 4'h1, bn_t[k]});
      burst(ba_t[k], bl_t[k][0], 1'b0, 1'b1, bw_t[k]);
    end
    results();
  end
endmodule
